// File: common/pwrevt_pkg.sv
// package: register layout and constants for the power event status register
package pwrevt_pkg;
    // register location within the memory controller register space
    localparam logic [11:0] PWREVT_STATUS_OFFSET = 12'hf14;
    localparam logic [31:0] PWREVT_STATUS_RESET  = 32'h0000_0000;
    // field positions
    localparam int          PWREVT_CH0_BIT       = 0;
    localparam int          PWREVT_CH1_BIT       = 1;
    localparam int          PWREVT_WARM_BIT      = 8;
    // reset value of a single flag
    localparam logic        PWREVT_FLAG_RESET    = 1'b0;
endpackage

// File: rtl/pwrevt_flag.sv
// one sticky status flag: hardware set, hardware clear, write-one clear
`timescale 1ns/1ps
module pwrevt_flag
    import pwrevt_pkg::*;
(
    // clock and power-good clear
    input  wire logic clk_i,
    input  wire logic pg_clear_i,
    // set and clear sources
    input  wire logic set_i,
    input  wire logic hw_clear_i,
    input  wire logic sw_clear_i,
    // flag value
    output logic      flag_o
);
    logic next_flag;

    // set wins over hardware and write-one clears so no event is lost
    assign next_flag = set_i ? 1'b1 : ((hw_clear_i | sw_clear_i) ? 1'b0 : flag_o);

    // loss of power-good forces the flag to zero, ahead of set and clears
    always_ff @(posedge clk_i)
    begin
        if (pg_clear_i)
        begin
            flag_o <= PWREVT_FLAG_RESET;
        end
        else
        begin
            flag_o <= next_flag;
        end
    end
endmodule

// File: rtl/pwrevt_status.sv
// power event status register: warm reset and channel self-refresh flags
//
// Functional notes
// - only power-good loss resets register to zero
// - warm reset received sets bit 8
// - power-good low clears warm reset flag
// - channel 1 in self-refresh sets bit 1
// - channel 0 in self-refresh sets bit 0
// - channel 1 flag cleared before exit starts
// - channel 0 flag cleared before exit starts
// - writing one clears channel flags
// - one means in self-refresh, zero unknown
`timescale 1ns/1ps
module pwrevt_status
    import pwrevt_pkg::*;
(
    // clock and platform reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // power-good from the platform, asynchronous pin
    input  wire logic        power_good_i,
    // events from the power management unit and channel controllers
    input  wire logic        warm_reset_evt_i,
    input  wire logic        ch0_sr_entered_i,
    input  wire logic        ch1_sr_entered_i,
    input  wire logic        ch0_sr_exit_start_i,
    input  wire logic        ch1_sr_exit_start_i,
    // register access port
    input  wire logic [11:0] reg_addr_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    input  wire logic [31:0] reg_wdata_i,
    output logic      [31:0] reg_rdata_o,
    // flag outputs to the power management unit
    output logic             warm_reset_seen_o,
    output logic             chan1_selfrefresh_flag_o,
    output logic             chan0_selfrefresh_flag_o
);
    // port timing, as seen from the far side
    // - an event pulse sets its flag at the edge where it is seen high
    // - the flag copies on the outputs follow one cycle after the flag
    // - read data stands one cycle after the read strobe, zero otherwise
    // - an event and an exit or write-one clear on one flag in one cycle: the event wins
    // - a read and a write in one cycle return the value before the write
    // - power-good low clears every flag three edges after the pin falls
    // - rst_i clears only the read data register, never a flag
    //
    // limitations
    // - power-good must stay low for at least one clock to take effect
    // - flags hold unknown values until power-good low has been seen

    // power-good synchroniser stages
    logic        pg_meta;
    logic        pg_sync;
    logic        pg_clear;

    // register decode
    logic        hit;
    logic        wr_hit;
    logic        rd_hit;

    // write-one-clear strobes from firmware
    logic        w1c_ch0;
    logic        w1c_ch1;
    logic        w1c_warm;

    // hardware set and clear requests per flag
    logic        set_warm;
    logic        set_ch1;
    logic        set_ch0;
    logic        hw_clr_warm;
    logic        hw_clr_ch1;
    logic        hw_clr_ch0;

    // live flag values
    logic        warm_reset_seen;
    logic        chan1_selfrefresh_flag;
    logic        chan0_selfrefresh_flag;

    // read path
    logic [31:0] status_word;
    logic [31:0] next_rdata;

    // next values of the flag copies
    logic        next_warm_reset_seen_o;
    logic        next_chan1_selfrefresh_flag_o;
    logic        next_chan0_selfrefresh_flag_o;

    // power-good passes two flip-flops without reset; flags clear once it is seen low
    always_ff @(posedge clk_i)
    begin
        pg_meta <= power_good_i;
        pg_sync <= pg_meta;
    end

    assign pg_clear = ~pg_sync;

    // address decode; the register is one aligned word
    assign hit      = (reg_addr_i == PWREVT_STATUS_OFFSET);
    assign wr_hit   = reg_wr_i & hit;
    assign rd_hit   = reg_rd_i & hit;

    // write one clears
    // only the three flag positions react; other written ones are dropped
    assign w1c_ch0  = wr_hit & reg_wdata_i[PWREVT_CH0_BIT];
    assign w1c_ch1  = wr_hit & reg_wdata_i[PWREVT_CH1_BIT];
    assign w1c_warm = wr_hit & reg_wdata_i[PWREVT_WARM_BIT];

    // warm reset event
    // the warm flag has no hardware clear besides power-good
    assign set_warm    = warm_reset_evt_i;
    assign hw_clr_warm = 1'b0;

    // channel 1 entry and exit
    // the exit pulse arrives ahead of the exit sequence itself
    assign set_ch1     = ch1_sr_entered_i;
    assign hw_clr_ch1  = ch1_sr_exit_start_i;

    assign set_ch0     = ch0_sr_entered_i;
    assign hw_clr_ch0  = ch0_sr_exit_start_i;

    pwrevt_flag u_warm (
        .clk_i      (clk_i),
        .pg_clear_i (pg_clear),
        .set_i      (set_warm),
        .hw_clear_i (hw_clr_warm),
        .sw_clear_i (w1c_warm),
        .flag_o     (warm_reset_seen)
    );

    pwrevt_flag u_ch1 (
        .clk_i      (clk_i),
        .pg_clear_i (pg_clear),
        .set_i      (set_ch1),
        .hw_clear_i (hw_clr_ch1),
        .sw_clear_i (w1c_ch1),
        .flag_o     (chan1_selfrefresh_flag)
    );

    pwrevt_flag u_ch0 (
        .clk_i      (clk_i),
        .pg_clear_i (pg_clear),
        .set_i      (set_ch0),
        .hw_clear_i (hw_clr_ch0),
        .sw_clear_i (w1c_ch0),
        .flag_o     (chan0_selfrefresh_flag)
    );

    always_comb
    begin
        status_word                   = PWREVT_STATUS_RESET;
        status_word[PWREVT_CH0_BIT]   = chan0_selfrefresh_flag;
        status_word[PWREVT_CH1_BIT]   = chan1_selfrefresh_flag;
        status_word[PWREVT_WARM_BIT]  = warm_reset_seen;
    end

    // unmapped reads and idle cycles return zero
    assign next_rdata = rd_hit ? status_word : 32'h0000_0000;

    // copies for the power management unit trail the live flags by one cycle
    assign next_warm_reset_seen_o        = warm_reset_seen;
    assign next_chan1_selfrefresh_flag_o = chan1_selfrefresh_flag;
    assign next_chan0_selfrefresh_flag_o = chan0_selfrefresh_flag;

    // read data only
    // read data register; rst_i clears it but never a flag
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 32'h0000_0000;
        end
        else
        begin
            reg_rdata_o <= next_rdata;
        end
    end

    // flag copies; no reset, they simply follow the flags
    always_ff @(posedge clk_i)
    begin
        warm_reset_seen_o        <= next_warm_reset_seen_o;
        chan1_selfrefresh_flag_o <= next_chan1_selfrefresh_flag_o;
        chan0_selfrefresh_flag_o <= next_chan0_selfrefresh_flag_o;
    end
endmodule

// File: verif/pwrevt_pm_model.sv
// model of the power management unit and the two channel controllers
`timescale 1ns/1ps
module pwrevt_pm_model
(
    // clock and requested events: ch0 set, ch1 set, warm, ch0 exit, ch1 exit
    input  wire logic       clk_i,
    input  wire logic [4:0] cmd_i,
    // one-cycle event pulses
    output logic      [4:0] evt_o
);
    always_ff @(posedge clk_i)
    begin
        evt_o <= cmd_i;
    end
endmodule

// File: verif/pwrevt_status_checker.sv
// checker: port assertions for the power event status register
`timescale 1ns/1ps
module pwrevt_status_checker
    import pwrevt_pkg::*;
(
    // all ports of the status register
    input wire logic        clk_i, rst_i, power_good_i, warm_reset_evt_i, reg_wr_i, reg_rd_i,
    input wire logic        ch0_sr_entered_i, ch1_sr_entered_i, ch0_sr_exit_start_i,
    input wire logic        ch1_sr_exit_start_i, warm_reset_seen_o,
    input wire logic        chan1_selfrefresh_flag_o, chan0_selfrefresh_flag_o,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o
);
    // address decode and shared clocking
    wire hit = reg_addr_i == PWREVT_STATUS_OFFSET;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i || !power_good_i);
    // flags follow their causes two cycles later, power-good loss after four low samples
    chk_warm_set: assert property (warm_reset_evt_i |-> ##2 warm_reset_seen_o)
        else $error("warm unset");
    chk_ch1_set: assert property (ch1_sr_entered_i |-> ##2 chan1_selfrefresh_flag_o)
        else $error("ch1 unset");
    chk_ch0_set: assert property (ch0_sr_entered_i |-> ##2 chan0_selfrefresh_flag_o)
        else $error("ch0 unset");
    chk_ch1_exit: assert property (ch1_sr_exit_start_i && !ch1_sr_entered_i
        |-> ##2 !chan1_selfrefresh_flag_o) else $error("ch1 kept");
    chk_ch0_exit: assert property (ch0_sr_exit_start_i && !ch0_sr_entered_i
        |-> ##2 !chan0_selfrefresh_flag_o) else $error("ch0 kept");
    chk_w1c_clear: assert property (reg_wr_i && hit && reg_wdata_i[0] && !ch0_sr_entered_i
        |-> ##2 !chan0_selfrefresh_flag_o) else $error("w1c kept");
    chk_w1c_ch1: assert property (reg_wr_i && hit && reg_wdata_i[1] && !ch1_sr_entered_i
        |-> ##2 !chan1_selfrefresh_flag_o) else $error("w1c ch1 kept");
    chk_w1c_warm: assert property (reg_wr_i && hit && reg_wdata_i[8] && !warm_reset_evt_i
        |-> ##2 !warm_reset_seen_o) else $error("w1c warm kept");
    chk_read_word: assert property (reg_rd_i && hit |=> reg_rdata_o == {23'h0,
        warm_reset_seen_o, 6'h0, chan1_selfrefresh_flag_o, chan0_selfrefresh_flag_o})
        else $error("bad word");
    chk_pg_clear: assert property (disable iff (1'b0) !power_good_i [*4] |=>
        !(warm_reset_seen_o || chan1_selfrefresh_flag_o || chan0_selfrefresh_flag_o))
        else $error("pg kept");
    // main scenarios reached
    cover property (reg_wr_i && hit && chan0_selfrefresh_flag_o);
    cover property ($fell(rst_i) && warm_reset_seen_o);
    cover property (ch1_sr_exit_start_i && chan1_selfrefresh_flag_o);
endmodule
bind pwrevt_status pwrevt_status_checker u_chk (.*);

// File: verif/pwrevt_status_tb_top.sv
// bench: random and corner traffic on the power event status register
`timescale 1ns/1ps
module pwrevt_status_tb_top
    import pwrevt_pkg::*;
;
    localparam logic [11:0] A = PWREVT_STATUS_OFFSET;
    logic clk_i = 0, rst_i = 1, power_good_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic warm_reset_evt_i, ch0_sr_entered_i, ch1_sr_entered_i, ch0_sr_exit_start_i;
    logic ch1_sr_exit_start_i, warm_reset_seen_o, chan1_selfrefresh_flag_o;
    logic chan0_selfrefresh_flag_o;
    logic [4:0] cmd = 0;
    logic [11:0] reg_addr_i = 0;
    logic [31:0] reg_wdata_i = 0, reg_rdata_o;
    logic [2:0] m = 0;
    int err_count = 0, compares = 0;
    wire [2:0] fl = {warm_reset_seen_o, chan1_selfrefresh_flag_o, chan0_selfrefresh_flag_o};
    // clock, partner and design
    always #20 clk_i = ~clk_i;
    pwrevt_pm_model PM (.clk_i, .cmd_i(cmd), .evt_o({ch1_sr_exit_start_i, ch0_sr_exit_start_i,
        warm_reset_evt_i, ch1_sr_entered_i, ch0_sr_entered_i}));
    pwrevt_status DUT (.*);
    // expected word from the shadow flags {warm, ch1, ch0}
    function automatic logic [31:0] exp_word(logic [11:0] a);
        return a == A ? {23'h0, m[2], 6'h0, m[1:0]} : 32'h0;
    endfunction
    task automatic chk(logic [31:0] g, logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    // read, write and event drivers keep the shadow in step
    task automatic rdc(logic [11:0] a);
        @(posedge clk_i) {reg_rd_i, reg_addr_i} <= {1'b1, a};
        @(posedge clk_i) reg_rd_i <= 1'b0;
        #1 chk(reg_rdata_o, exp_word(a));
        chk({29'h0, fl}, {29'h0, m});
    endtask
    task automatic wrc(logic [31:0] d);
        @(posedge clk_i) {reg_wr_i, reg_addr_i, reg_wdata_i} <= {1'b1, A, d};
        @(posedge clk_i) reg_wr_i <= 1'b0;
        m = m & ~{d[8], d[1:0]};
    endtask
    task automatic ev(int b);
        @(posedge clk_i) cmd <= 5'(1 << b);
        @(posedge clk_i) cmd <= 5'h0;
        @(posedge clk_i);
        m = b < 3 ? m | 3'(1 << b) : m & ~3'(1 << (b - 3));
    endtask
    task automatic results;
        $display("err_count %0d compares %0d", err_count, compares);
        if (err_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // random mix, then platform reset and power loss with all flags set
    initial
    begin
        int r;
        void'($urandom(59));
        repeat (8) @(posedge clk_i);
        {rst_i, power_good_i} <= 2'b01;
        repeat (4) @(posedge clk_i);
        repeat (80)
        begin
            r = $urandom % 8;
            if (r < 5) ev(r);
            else if (r == 5) wrc($urandom);
            else rdc(r == 6 ? A : 12'($urandom));
        end
        for (r = 0; r < 3; r++) ev(r);
        @(posedge clk_i) rst_i <= 1'b1;
        @(posedge clk_i) rst_i <= 1'b0;
        rdc(A);
        @(posedge clk_i) power_good_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        power_good_i <= 1'b1;
        m = 3'h0;
        repeat (4) @(posedge clk_i);
        rdc(A);
        results();
    end
    // watchdog far beyond the run of about 250 cycles
    initial
    begin
        #100us;
        err_count++;
        results();
    end
endmodule
